// ===== inc/ait_pkg.sv
// Constants and types shared by the audio interval timer
package ait_pkg;
    localparam int unsigned IDX_W = 6;
    localparam int unsigned DAT_W = 16;
    localparam int unsigned PRE_W = 20;

    typedef logic [IDX_W-1:0] ait_idx_t;
    typedef logic [DAT_W-1:0] ait_data_t;
    typedef logic [PRE_W-1:0] ait_pre_t;

    // Indirect register indices
    localparam ait_idx_t IDX_IRQ_CTRL = 6'h01;
    localparam ait_idx_t IDX_RELOAD   = 6'h0c;
    localparam ait_idx_t IDX_LIVE     = 6'h0d;
    localparam ait_idx_t IDX_PWR_TMR  = 6'h2c;

    // Field positions
    localparam int unsigned BIT_COUNTDOWN_IRQ_GATE = 13;
    localparam int unsigned BIT_LEGACY_IRQ_GATE    = 8;
    localparam int unsigned BIT_TIMER_RUN_ENABLE   = 7;
    localparam int unsigned BIT_TICK_PERIOD_SELECT = 8;

    // Reset values
    localparam ait_data_t RST_IRQ_CTRL = 16'h0102;
    localparam ait_data_t RST_PWR_TMR  = 16'h0000;
    localparam ait_data_t RST_RELOAD   = 16'h0000;
    localparam ait_data_t RST_LIVE     = 16'h0000;

    // Tick timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TICK_SHORT_NS = 10_000;
    localparam int unsigned TICK_LONG_MS  = 100;
    localparam int unsigned SHORT_CYC = TICK_SHORT_NS / CLK_PERIOD_NS;
    localparam int unsigned LONG_CYC  =
        TICK_LONG_MS * 1_000_000 / CLK_PERIOD_NS;
endpackage : ait_pkg

// ===== inc/ait_tick_if.sv
// Link between the countdown core and its tick prescaler
`timescale 1ns/10ps
interface ait_tick_if;
    logic run;
    logic period_sel;
    logic tick;
    modport gen  (input run, input period_sel, output tick);
    modport user (output run, output period_sel, input tick);
endinterface : ait_tick_if

// ===== core/ait_tick_gen.sv
// Tick prescaler producing one pulse per selected period
`timescale 1ns/10ps
module ait_tick_gen #(
    parameter ait_pkg::ait_pre_t LONG_CYC =
        ait_pkg::ait_pre_t'(ait_pkg::LONG_CYC)
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    ait_tick_if.gen   tk
);
    import ait_pkg::*;

    localparam ait_pre_t SHORT_LIM = ait_pre_t'(SHORT_CYC - 1);

    ait_pre_t cnt;
    logic     sel_q;
    logic     tick_q;

    wire ait_pre_t lim      = tk.period_sel ? LONG_CYC - 20'h00001 : SHORT_LIM;
    wire logic     restart  = !tk.run || (tk.period_sel != sel_q);
    wire logic     at_limit = (cnt == lim);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt    <= '0;
            sel_q  <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            sel_q  <= tk.period_sel;
            cnt    <= (restart || at_limit) ? '0 : cnt + 20'h00001;
            tick_q <= !restart && at_limit;
        end
    end

    assign tk.tick = tick_q;
endmodule : ait_tick_gen

// ===== core/ait_timer.sv
// Audio interval timer: indirect registers and 16-bit countdown
`timescale 1ns/10ps
module ait_timer #(
    parameter ait_pkg::ait_pre_t LONG_CYC =
        ait_pkg::ait_pre_t'(ait_pkg::LONG_CYC)
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire ait_pkg::ait_idx_t reg_idx,
    input  wire ait_pkg::ait_data_t wr_data,
    output logic                   rd_valid,
    output ait_pkg::ait_data_t     rd_data,
    output logic                   expiry_evt,
    output logic                   timer_irq
);
    import ait_pkg::*;

    function automatic logic idx_hit(input ait_idx_t idx,
                                     input ait_idx_t target);
        idx_hit = (idx == target);
    endfunction : idx_hit

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic      countdown_irq_gate;
    logic      legacy_irq_gate;
    logic      timer_run_enable;
    logic      tick_period_select;
    ait_data_t timer_reload_value;
    ait_data_t timer_live_count;

    wire logic wr_ctrl   = wr_en && idx_hit(reg_idx, IDX_IRQ_CTRL);
    wire logic wr_pwr    = wr_en && idx_hit(reg_idx, IDX_PWR_TMR);
    wire logic wr_reload = wr_en && idx_hit(reg_idx, IDX_RELOAD);
    wire logic wr_live   = wr_en && idx_hit(reg_idx, IDX_LIVE);
    wire logic wr_count  = wr_reload || wr_live;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            countdown_irq_gate <= RST_IRQ_CTRL[BIT_COUNTDOWN_IRQ_GATE];
            legacy_irq_gate    <= RST_IRQ_CTRL[BIT_LEGACY_IRQ_GATE];
            timer_run_enable   <= RST_IRQ_CTRL[BIT_TIMER_RUN_ENABLE];
            tick_period_select <= RST_PWR_TMR[BIT_TICK_PERIOD_SELECT];
            timer_reload_value <= RST_RELOAD;
        end else begin
            if (wr_ctrl) begin
                countdown_irq_gate <= wr_data[BIT_COUNTDOWN_IRQ_GATE];
                legacy_irq_gate    <= wr_data[BIT_LEGACY_IRQ_GATE];
                timer_run_enable   <= wr_data[BIT_TIMER_RUN_ENABLE];
            end
            if (wr_pwr) begin
                tick_period_select <= wr_data[BIT_TICK_PERIOD_SELECT];
            end
            if (wr_reload) begin
                timer_reload_value <= wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tick source and countdown
    ait_tick_if tk ();

    wire logic run = timer_run_enable && legacy_irq_gate;

    assign tk.run        = run;
    assign tk.period_sel = tick_period_select;

    ait_tick_gen #(.LONG_CYC(LONG_CYC)) u_tick (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tk      (tk)
    );

    wire logic      step      = tk.tick && run && !wr_count;
    wire logic      at_zero   = (timer_live_count == 16'h0000);
    wire logic      expire    = step && at_zero;
    wire ait_data_t next_live =
        wr_count ? wr_data :
        expire   ? timer_reload_value :
        step     ? timer_live_count - 16'h0001 :
                   timer_live_count;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer_live_count <= RST_LIVE;
            expiry_evt       <= 1'b0;
            timer_irq        <= 1'b0;
        end else begin
            timer_live_count <= next_live;
            expiry_evt       <= expire;
            timer_irq        <= expire && countdown_irq_gate;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, answers one cycle after the strobe
    wire ait_data_t ctrl_word =
        (ait_data_t'(countdown_irq_gate) << BIT_COUNTDOWN_IRQ_GATE) |
        (ait_data_t'(legacy_irq_gate)    << BIT_LEGACY_IRQ_GATE) |
        (ait_data_t'(timer_run_enable)   << BIT_TIMER_RUN_ENABLE);
    wire ait_data_t pwr_word  =
        ait_data_t'({7'h00, tick_period_select, 8'h00});
    wire ait_data_t next_rd_data =
        idx_hit(reg_idx, IDX_IRQ_CTRL) ? ctrl_word :
        idx_hit(reg_idx, IDX_PWR_TMR)  ? pwr_word :
        idx_hit(reg_idx, IDX_RELOAD)   ? timer_reload_value :
        idx_hit(reg_idx, IDX_LIVE)     ? timer_live_count : 16'h0000;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data  <= 16'h0000;
        end else begin
            rd_valid <= rd_en;
            rd_data  <= rd_en ? next_rd_data : rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    ait_pre_t gap;
    logic     sel_seen;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gap      <= '0;
            sel_seen <= 1'b0;
        end else begin
            sel_seen <= tick_period_select;
            // Prescaler wraps to zero on the same edge that raises its tick
            if (!run || tick_period_select != sel_seen) begin
                gap <= '0;
            end else if (tk.tick) begin
                gap <= 20'h00001;
            end else begin
                gap <= gap + 20'h00001;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_expire;
        tk.tick && run && at_zero && !wr_count;
    endsequence

    sequence s_reloaded;
        timer_live_count == $past(timer_reload_value) && expiry_evt;
    endsequence

    chk_reload_load: assert property (
        wr_reload |=> timer_live_count == $past(wr_data)
                      && timer_reload_value == $past(wr_data))
        else $error("reload write did not load live count");

    chk_count_step: assert property (
        tk.tick && run && !at_zero && !wr_count
        |=> timer_live_count == $past(timer_live_count) - 16'h0001)
        else $error("live count did not drop by one on tick");

    chk_count_hold: assert property (
        !tk.tick && !wr_count |=> $stable(timer_live_count))
        else $error("live count moved without a tick");

    chk_tick_period: assert property (
        tk.tick |-> ($past(gap) == ($past(tick_period_select) ?
                    LONG_CYC - 20'h00001 : ait_pre_t'(SHORT_CYC - 1))))
        else $error("tick spacing differs from selected period");

    chk_expiry_reload: assert property (
        s_expire |=> s_reloaded)
        else $error("expiry did not reload and signal");

    chk_gate_idle: assert property (
        !legacy_irq_gate && !wr_count
        ##1 !legacy_irq_gate && !wr_count |-> $stable(timer_live_count))
        else $error("count advanced while legacy gate clear");

    chk_irq_gate: assert property (
        expiry_evt |-> timer_irq == $past(countdown_irq_gate))
        else $error("interrupt output does not follow its gate");

    chk_irq_cause: assert property (
        timer_irq |-> expiry_evt)
        else $error("interrupt without expiry");
endmodule : ait_timer

// ===== tb/audio_interval_timer_tb.sv
// Self-checking bench for the audio interval timer
`timescale 1ns/10ps
module audio_interval_timer_tb;
    import ait_pkg::*;
    localparam int unsigned SIM_LONG = 200;
    typedef struct {
        bit        w;
        ait_idx_t  idx;
        ait_data_t d;
        ait_data_t e;
    } ait_row_t;
    logic      clk_sys;
    logic      reset_n;
    logic      wr_en;
    logic      rd_en;
    ait_idx_t  reg_idx;
    ait_data_t wr_data;
    logic      rd_valid;
    ait_data_t rd_data;
    logic      expiry_evt;
    logic      timer_irq;
    int        n_fail;
    int        n_tests;
    int        cyc;
    logic      irq_seen;
    ait_row_t  rows [11];
    int        per  [3][3];
    ait_timer #(.LONG_CYC(ait_pre_t'(SIM_LONG))) ait_timer_inst (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .wr_en     (wr_en),
        .rd_en     (rd_en),
        .reg_idx   (reg_idx),
        .wr_data   (wr_data),
        .rd_valid  (rd_valid),
        .rd_data   (rd_data),
        .expiry_evt(expiry_evt),
        .timer_irq (timer_irq)
    );
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk
    task automatic wr(input ait_idx_t idx, input ait_data_t d);
        @(negedge clk_sys);
        wr_en = 1'b1;
        reg_idx = idx;
        wr_data = d;
        @(negedge clk_sys);
        wr_en = 1'b0;
    endtask : wr
    task automatic rd(input ait_idx_t idx, input ait_data_t e);
        @(negedge clk_sys);
        rd_en = 1'b1;
        reg_idx = idx;
        @(negedge clk_sys);
        rd_en = 1'b0;
        chk({15'h0, rd_valid}, 16'h0001);
        chk(rd_data, e);
    endtask : rd
    // Cycles until the next expiry pulse, irq level captured with it
    task automatic wait_evt(output int c);
        c = 0;
        irq_seen = 1'b0;
        do begin
            @(negedge clk_sys);
            c++;
        end while (expiry_evt !== 1'b1 && c < 3000);
        irq_seen = timer_irq;
        if (c >= 3000) chk(16'hdead, 16'h0000);
    endtask : wait_evt
    task automatic complete_run;
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(100 * 30000);
        n_fail++;
        complete_run();
    end
    initial begin
        n_fail = 0;
        n_tests = 0;
        reset_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        reg_idx = 6'h00;
        wr_data = 16'h0000;
        rows = '{'{0, IDX_IRQ_CTRL, 16'h0, 16'h0100},
                 '{0, IDX_PWR_TMR, 16'h0, 16'h0000},
                 '{0, IDX_RELOAD, 16'h0, 16'h0000},
                 '{0, IDX_LIVE, 16'h0, 16'h0000},
                 '{1, 6'h02, 16'hffff, 16'h0000},
                 '{1, IDX_PWR_TMR, 16'hffff, 16'h0100},
                 '{1, IDX_IRQ_CTRL, 16'hff7f, 16'h2100},
                 '{1, IDX_RELOAD, 16'h1234, 16'h1234},
                 '{0, IDX_LIVE, 16'h0, 16'h1234},
                 '{1, IDX_LIVE, 16'h0055, 16'h0055},
                 '{0, IDX_RELOAD, 16'h0, 16'h1234}};
        per = '{'{0, 2, 300}, '{1, 0, SIM_LONG}, '{1, 1, 2 * SIM_LONG}};
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].idx, rows[i].d);
            rd(rows[i].idx, rows[i].e);
        end
        foreach (per[i]) begin
            wr(IDX_IRQ_CTRL, 16'h2100);
            wr(IDX_PWR_TMR, 16'(per[i][0]) << 8);
            wr(IDX_RELOAD, 16'(per[i][1]));
            wr(IDX_IRQ_CTRL, 16'h2180);
            wait_evt(cyc);
            chk({15'h0, irq_seen}, 16'h0001);
            wait_evt(cyc);
            chk(16'(cyc), 16'(per[i][2]));
            rd(IDX_LIVE, 16'(per[i][1]));
        end
        wr(IDX_IRQ_CTRL, 16'h0180);
        wait_evt(cyc);
        chk({15'h0, irq_seen}, 16'h0000);
        wait_evt(cyc);
        chk(16'(cyc), 16'(2 * SIM_LONG));
        // Run without the legacy gate, then gate without run: count holds
        for (int k = 0; k < 2; k++) begin
            wr(IDX_IRQ_CTRL, 16'h2000);
            wr(IDX_RELOAD, 16'h0005);
            wr(IDX_IRQ_CTRL, k == 0 ? 16'h2080 : 16'h2100);
            irq_seen = 1'b0;
            repeat (3 * SIM_LONG) begin
                @(negedge clk_sys);
                if (expiry_evt !== 1'b0) irq_seen = 1'b1;
            end
            chk({15'h0, irq_seen}, 16'h0000);
            rd(IDX_LIVE, 16'h0005);
        end
        wr(IDX_IRQ_CTRL, 16'h2180);
        repeat (150) @(negedge clk_sys);
        reset_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({14'h0, expiry_evt, timer_irq}, 16'h0000);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        rd(IDX_IRQ_CTRL, 16'h0100);
        rd(IDX_LIVE, 16'h0000);
        rd(IDX_RELOAD, 16'h0000);
        complete_run();
    end
endmodule : audio_interval_timer_tb
